/* File: pkg/wdcfg_pkg.sv */
`default_nettype none
package wdcfg_pkg;

  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  localparam int unsigned WIN_SEL_LSB = 24;
  localparam int unsigned FORCE_EN_BIT = 23;
  localparam int unsigned WIN_DIS_BIT = 22;
  localparam int unsigned RSVD_BIT = 21;
  localparam int unsigned PS_SEL_LSB = 16;
  localparam logic [4:0] PS_MAX = 5'h14;

  // ----------------------------------------
  // Window start in eighths of the period
  // ----------------------------------------
  localparam logic [3:0] WIN_START_25 = 4'h6;
  localparam logic [3:0] WIN_START_37 = 4'h5;
  localparam logic [3:0] WIN_START_50 = 4'h4;
  localparam logic [3:0] WIN_START_75 = 4'h2;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_CLR = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00C;
  localparam logic [11:0] ADDR_CNT = 12'h010;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [1:0] LOAD_WAIT = 2'h2;

  typedef struct packed {
    logic [1:0] win_sel;
    logic force_en;
    logic win_dis;
    logic [4:0] ps_sel;
  } wdcfg_fields_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_OFF = 3'b010,
    ST_RUN = 3'b100
  } wdcfg_state_t;

  function automatic wdcfg_fields_t decode_fields(input logic [31:0] w);
    wdcfg_fields_t f;
    f.win_sel = w[WIN_SEL_LSB +: 2];
    f.force_en = w[FORCE_EN_BIT];
    f.win_dis = w[WIN_DIS_BIT];
    f.ps_sel = w[PS_SEL_LSB +: 5];
    return f;
  endfunction

  function automatic logic [4:0] eff_ps(input logic [4:0] sel);
    return (sel > PS_MAX) ? PS_MAX : sel;
  endfunction

  function automatic logic [31:0] win_start(input logic [31:0] period, input logic [1:0] sel);
    logic [3:0] k;
    case (sel)
      2'b11: k = WIN_START_25;
      2'b10: k = WIN_START_37;
      2'b01: k = WIN_START_50;
      default: k = WIN_START_75;
    endcase
    return 32'((period >> 3) * k);
  endfunction

endpackage
`default_nettype wire

/* File: verilog/wdcfg_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module wdcfg_counter (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic windowed_i,
  input wire logic [31:0] period_i,
  input wire logic [31:0] open_at_i,
  // Status
  output logic [31:0] count_o,
  output logic timeout_o,
  output logic early_o
);

  // ----------------------------------------
  // Postscaled period counter
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o <= 32'h0000_0000;
    end else if (!run_i || clear_i || count_o >= period_i - 32'h0000_0001) begin
      count_o <= 32'h0000_0000;
    end else begin
      count_o <= count_o + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Expiry and early clear
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timeout_o <= 1'b0;
      early_o <= 1'b0;
    end else begin
      timeout_o <= run_i && !clear_i && count_o >= period_i - 32'h0000_0001;
      early_o <= run_i && clear_i && windowed_i && count_o < open_at_i;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/wdcfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module wdcfg_top #(
  parameter logic [31:0] TICK_CYC = 32'h0000_0008
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Non-volatile configuration word
  input wire logic [31:0] cfg_word_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Watchdog
  output logic wdt_reset_o,
  output logic wdt_running_o
);

  logic [31:0] cfg_sync1_q;
  logic [31:0] cfg_sync2_q;
  logic [31:0] cfg_word_q;
  logic [1:0] load_cnt_q;
  wdcfg_pkg::wdcfg_state_t state_q;
  wdcfg_pkg::wdcfg_fields_t fields;
  logic sw_en_q;
  logic timeout_seen_q;
  logic early_seen_q;
  logic [31:0] rd_d;
  logic hit;
  logic wr_acc;
  logic clr_pulse;
  logic run;
  logic [4:0] ps;
  logic [31:0] period;
  logic [31:0] open_at;
  logic [31:0] count;
  logic timeout;
  logic early;

  // ----------------------------------------
  // Configuration capture
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_sync1_q <= wdcfg_pkg::CFG_RST;
      cfg_sync2_q <= wdcfg_pkg::CFG_RST;
    end else begin
      cfg_sync1_q <= cfg_word_i;
      cfg_sync2_q <= cfg_sync1_q;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      load_cnt_q <= 2'h0;
      cfg_word_q <= wdcfg_pkg::CFG_RST;
    end else if (load_cnt_q != wdcfg_pkg::LOAD_WAIT) begin
      load_cnt_q <= load_cnt_q + 2'h1;
    end else if (state_q == wdcfg_pkg::ST_LOAD) begin
      cfg_word_q <= cfg_sync2_q;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    fields = wdcfg_pkg::decode_fields(cfg_word_q);
    ps = wdcfg_pkg::eff_ps(fields.ps_sel);
    period = TICK_CYC << ps;
    open_at = wdcfg_pkg::win_start(period, fields.win_sel);
    run = state_q == wdcfg_pkg::ST_RUN;
  end

  // ----------------------------------------
  // Enable state
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= wdcfg_pkg::ST_LOAD;
    end else begin
      case (state_q)
        wdcfg_pkg::ST_LOAD: begin
          if (load_cnt_q == wdcfg_pkg::LOAD_WAIT) begin
            state_q <= cfg_sync2_q[wdcfg_pkg::FORCE_EN_BIT] ? wdcfg_pkg::ST_RUN
                                                            : wdcfg_pkg::ST_OFF;
          end
        end
        wdcfg_pkg::ST_OFF: begin
          if (sw_en_q) begin
            state_q <= wdcfg_pkg::ST_RUN;
          end
        end
        wdcfg_pkg::ST_RUN: begin
          if (!fields.force_en && !sw_en_q) begin
            state_q <= wdcfg_pkg::ST_OFF;
          end
        end
        default: state_q <= wdcfg_pkg::ST_LOAD;
      endcase
    end
  end

  assign wdt_running_o = state_q[2];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_comb begin
    hit = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr_i)
      wdcfg_pkg::ADDR_CFG: rd_d = cfg_word_q;
      wdcfg_pkg::ADDR_CTRL: rd_d = {31'h0, sw_en_q};
      wdcfg_pkg::ADDR_CLR: rd_d = 32'h0000_0000;
      wdcfg_pkg::ADDR_STAT: rd_d = {27'h0, early_seen_q, timeout_seen_q,
                                    count >= open_at, !fields.win_dis, run};
      wdcfg_pkg::ADDR_CNT: rd_d = count;
      default: hit = 1'b0;
    endcase
    wr_acc = psel_i && penable_i && pready_o && pwrite_i && hit;
    clr_pulse = wr_acc && paddr_i == wdcfg_pkg::ADDR_CLR && pwdata_i[0];
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !hit;
      if (psel_i && !penable_i) begin
        prdata_o <= (pwrite_i || !hit) ? 32'h0000_0000 : rd_d;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sw_en_q <= wdcfg_pkg::CTRL_RST;
    end else if (wr_acc && paddr_i == wdcfg_pkg::ADDR_CTRL) begin
      sw_en_q <= pwdata_i[0];
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timeout_seen_q <= 1'b0;
      early_seen_q <= 1'b0;
    end else begin
      if (timeout) begin
        timeout_seen_q <= 1'b1;
      end else if (wr_acc && paddr_i == wdcfg_pkg::ADDR_STAT && pwdata_i[3]) begin
        timeout_seen_q <= 1'b0;
      end
      if (early) begin
        early_seen_q <= 1'b1;
      end else if (wr_acc && paddr_i == wdcfg_pkg::ADDR_STAT && pwdata_i[4]) begin
        early_seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Counter and reset output
  // ----------------------------------------
  wdcfg_counter u_counter (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .run_i(run),
    .clear_i(clr_pulse),
    .windowed_i(!fields.win_dis),
    .period_i(period),
    .open_at_i(open_at),
    .count_o(count),
    .timeout_o(timeout),
    .early_o(early)
  );

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= timeout || early;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_win_25;
    run && !fields.win_dis && fields.win_sel == 2'b11 && clr_pulse
      && count < 32'((period >> 3) * wdcfg_pkg::WIN_START_25) |=> early;
  endproperty
  a_win_25: assert property (p_win_25) else $error("early clear not flagged");

  property p_win_75;
    run && !fields.win_dis && fields.win_sel == 2'b00 && clr_pulse
      && count >= (period >> 2) |=> !early;
  endproperty
  a_win_75: assert property (p_win_75) else $error("clear in window flagged");

  property p_force_on;
    run && fields.force_en |=> run [*3];
  endproperty
  a_force_on: assert property (p_force_on) else $error("forced watchdog stopped");

  property p_off_reset;
    state_q == wdcfg_pkg::ST_LOAD ##1 state_q != wdcfg_pkg::ST_LOAD && !fields.force_en
      |-> state_q == wdcfg_pkg::ST_OFF;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("watchdog on after reset");

  property p_sw_on;
    state_q == wdcfg_pkg::ST_OFF && sw_en_q |=> run ##1 wdt_running_o;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("software enable ignored");

  property p_no_window;
    run && fields.win_dis && clr_pulse |=> !early ##1 !wdt_reset_o;
  endproperty
  a_no_window: assert property (p_no_window) else $error("violation in plain mode");

  property p_ps;
    fields.ps_sel <= wdcfg_pkg::PS_MAX |-> period == TICK_CYC << fields.ps_sel;
  endproperty
  a_ps: assert property (p_ps) else $error("postscale period wrong");

  property p_ps_sat;
    fields.ps_sel > wdcfg_pkg::PS_MAX |-> period == TICK_CYC << wdcfg_pkg::PS_MAX;
  endproperty
  a_ps_sat: assert property (p_ps_sat) else $error("postscale not saturated");

  property p_expire;
    run && !clr_pulse && count == period - 32'h0000_0001 |-> ##2 wdt_reset_o;
  endproperty
  a_expire: assert property (p_expire) else $error("no reset on expiry");

  property p_early_rst;
    early |=> wdt_reset_o && early_seen_q;
  endproperty
  a_early_rst: assert property (p_early_rst) else $error("violation gave no reset");

  c_timeout: cover property (timeout);
  c_early: cover property (early);
  c_sw_on: cover property (state_q == wdcfg_pkg::ST_OFF ##1 run);
  c_sat: cover property (run && fields.ps_sel > wdcfg_pkg::PS_MAX);

endmodule
`default_nettype wire

/* File: test/wdcfg_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module wdcfg_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [31:0] cfg_word_i = 32'h0000_0000;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic wdt_reset_o;
  logic wdt_running_o;
  int n_fail = 0;
  int n_tests = 0;
  int n_rst = 0;
  logic [31:0] rd;
  logic er;

  wdcfg_top #(.TICK_CYC(32'h0000_0008)) wdcfg_top_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cfg_word_i(cfg_word_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .wdt_reset_o(wdt_reset_o), .wdt_running_o(wdt_running_o)
  );

  // ----------------------------------------
  // Clock, pulse counter, helpers
  // ----------------------------------------
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (wdt_reset_o === 1'b1) begin
      n_rst <= n_rst + 1;
    end
  end

  task automatic finish_test;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Reserved bits 31:26 and 21 written as one, bits 15:0 as zero
  function automatic logic [31:0] cw(input logic [1:0] ws, input logic fe, input logic wd,
                                     input logic [4:0] ps);
    return {6'h3F, ws, fe, wd, 1'b1, ps, 16'h0000};
  endfunction

  task automatic rst(input logic [31:0] cfg);
    reset_i <= 1'b1;
    cfg_word_i <= cfg;
    cyc(16);
    reset_i <= 1'b0;
    cyc(4);
  endtask

  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk("pready", 32'h0000_0001, {31'h0, pready_o});
    @(posedge core_clk_i);
  endtask

  task automatic wait_pulse(output int c);
    int n0;
    n0 = n_rst;
    c = 0;
    do begin
      cyc(1);
      c++;
    end while (n_rst == n0 && c < 2000);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_cfg;
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      w = cw(2'(i), i[0], i[1], 5'(i * 7));
      rst(w);
      apb(1'b0, wdcfg_pkg::ADDR_CFG, 32'h0000_0000);
      chk("cfg", w, rd);
      apb(1'b0, wdcfg_pkg::ADDR_STAT, 32'h0000_0000);
      chk("stat_run", {31'h0, i[0]}, {31'h0, rd[0]});
      chk("stat_win", {31'h0, ~i[1]}, {31'h0, rd[1]});
    end
  endtask

  task automatic t_enable;
    rst(cw(2'h0, 1'b1, 1'b1, 5'h03));
    apb(1'b1, wdcfg_pkg::ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, wdcfg_pkg::ADDR_CTRL, 32'h0000_0000);
    cyc(4);
    chk("forced_run", 32'h0000_0001, {31'h0, wdt_running_o});
    rst(cw(2'h0, 1'b0, 1'b1, 5'h03));
    cyc(8);
    chk("off_run", 32'h0000_0000, {31'h0, wdt_running_o});
    apb(1'b0, wdcfg_pkg::ADDR_CTRL, 32'h0000_0000);
    chk("ctrl_rst", 32'h0000_0000, rd);
    apb(1'b1, wdcfg_pkg::ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    chk("sw_run", 32'h0000_0001, {31'h0, wdt_running_o});
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, er});
    chk("unmapped_data", 32'h0000_0000, rd);
  endtask

  task automatic t_period;
    int c;
    for (int ps = 0; ps < 7; ps++) begin
      rst(cw(2'h0, 1'b1, 1'b1, 5'(ps)));
      wait_pulse(c);
      wait_pulse(c);
      chk("period", 32'h0000_0008 << ps, 32'(c));
    end
    for (int j = 0; j < 2; j++) begin
      rst(cw(2'h0, 1'b1, 1'b1, j ? 5'h1F : 5'h15));
      wait_pulse(c);
      chk("ps_clamp", 32'h0000_07D0, 32'(c));
    end
  endtask

  task automatic t_window;
    int opn[4] = '{16, 32, 40, 48};
    int n0;
    int g;
    logic [1:0] ws;
    logic wd;
    for (int i = 0; i < 5; i++) begin
      ws = (i == 4) ? 2'h3 : 2'(i);
      wd = (i == 4);
      rst(cw(ws, 1'b1, wd, 5'h03));
      for (int late = 0; late < 2; late++) begin
        g = late ? opn[ws] + 2 : opn[ws] - 6;
        apb(1'b1, wdcfg_pkg::ADDR_CLR, 32'h0000_0001);
        cyc(g);
        n0 = n_rst;
        apb(1'b1, wdcfg_pkg::ADDR_CLR, 32'h0000_0001);
        cyc(5);
        chk("early", {31'h0, ~wd & ~late[0]}, 32'(n_rst - n0));
        if (late == 0) begin
          apb(1'b0, wdcfg_pkg::ADDR_STAT, 32'h0000_0000);
          chk("early_seen", {31'h0, ~wd}, {31'h0, rd[4]});
          apb(1'b1, wdcfg_pkg::ADDR_STAT, 32'h0000_0018);
          apb(1'b0, wdcfg_pkg::ADDR_STAT, 32'h0000_0000);
          chk("early_w1c", 32'h0000_0000, {31'h0, rd[4]});
        end
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    cyc(60000);
    n_fail++;
    finish_test();
  end

  initial begin
    t_cfg();
    t_enable();
    t_period();
    t_window();
    finish_test();
  end
endmodule
`default_nettype wire
